// [cprs_map.svh]
`ifndef CPRS_MAP_SVH
`define CPRS_MAP_SVH
`define CPRS_ADDR_W 18
`define CPRS_CMD_W 5
`define CPRS_CS_W 4
`define CPRS_MODE_W 2
`define CPRS_MODE_DUAL 2'h0
`define CPRS_MODE_QUAD_DIRECT 2'h1
`define CPRS_MODE_QUAD_ENC 2'h3
`define CPRS_MODE_RSVD 2'h2
`define CPRS_PAR_EN_RESET 1'h0
`define CPRS_MODE_RESET 2'h0
`define CPRS_CTRL_DEPTH 16
`define CPRS_CTRL_AW 4
`define CPRS_CTRL_DW 8
`define CPRS_PAR_WORD_IDX 4'hE
`define CPRS_CFG_WORD_IDX 4'hD
`define CPRS_PAR_EN_BIT 0
`define CPRS_MODE_LSB 0
`endif

// [cprs_pkg.sv]
package cprs_pkg;
  typedef enum logic [2:0] {
    CPRS_ST_IDLE = 3'h1,
    CPRS_ST_FWD = 3'h2,
    CPRS_ST_ERR = 3'h4
  } cprs_state_t;
endpackage : cprs_pkg

// [cprs_ctrl_mem.sv]
`timescale 1ns/100ps
`default_nettype none
`include "cprs_map.svh"
module cprs_ctrl_mem #(
  parameter int DEPTH = `CPRS_CTRL_DEPTH,
  parameter int AW = `CPRS_CTRL_AW,
  parameter int DW = `CPRS_CTRL_DW
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem_reg [DEPTH];
  logic [DW-1:0] rd_data_reg;
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem_reg[wr_addr] <= wr_data;
    end
    if (srst)
    begin
      rd_data_reg <= '0;
    end
    else
    begin
      rd_data_reg <= mem_reg[rd_addr];
    end
  end
  assign rd_data = rd_data_reg;
endmodule : cprs_ctrl_mem
`default_nettype wire

// [cprs_top.sv]
// Function
// - Control word bit enables parity checking.
// - Host parity compared against qualified command inputs.
// - Mismatch drives open-drain alert low.
// - Enabled: forward only error-free commands.
// - Disabled: forward every chip-selected command except control word writes.
// - Control word writes are parity checked.
// - Chip selects choose the receiving rank.
// - Two-bit field picks one of three modes.
`timescale 1ns/100ps
`default_nettype none
`include "cprs_map.svh"
module cprs_top #(
  parameter int AW = `CPRS_ADDR_W,
  parameter int CW = `CPRS_CMD_W,
  parameter int SW = `CPRS_CS_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [SW-1:0] cs_in_n,
  input wire logic [CW-1:0] cmd_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic cmd_addr_parity_in,
  input wire logic ctrl_word_wr,
  output logic [SW-1:0] cs_out_n,
  output logic [CW-1:0] cmd_out,
  output logic [AW-1:0] addr_out,
  output logic cmd_valid_out,
  output logic alert_out,
  output logic alert_oe_n,
  output logic parity_err_out,
  output logic parity_en_out,
  output logic [1:0] rank_mode_field
);
  // Host pins pass two stages before any logic reads them; this costs two cycles of latency.
  logic [SW-1:0] cs_s1_reg, cs_s2_reg;
  logic [CW-1:0] cmd_s1_reg, cmd_s2_reg;
  logic [AW-1:0] addr_s1_reg, addr_s2_reg;
  logic par_s1_reg, par_s2_reg;
  logic wr_s1_reg, wr_s2_reg;
  logic [SW-1:0] cs_out_reg, cs_out_next;
  logic [CW-1:0] cmd_out_reg, cmd_out_next;
  logic [AW-1:0] addr_out_reg, addr_out_next;
  logic valid_reg, valid_next, perr_reg, perr_next;
  logic parity_en_reg, parity_en_next;
  logic [1:0] mode_reg, mode_next;
  cprs_pkg::cprs_state_t state_reg, state_next;
  logic [`CPRS_CTRL_DW-1:0] rd_data;
  logic qualified, mismatch, accept, mem_wr;
  logic alert_oe_n_reg, alert_oe_n_next;
  logic alert_out_reg, alert_out_next;
  logic [`CPRS_CTRL_AW-1:0] word_idx;
  logic [`CPRS_CTRL_DW-1:0] word_data;

  function automatic logic cprs_even_fail(input logic [CW-1:0] c, input logic [AW-1:0] a, input logic p);
    cprs_even_fail = ^{c, a, p};
  endfunction : cprs_even_fail

  function automatic logic [`CPRS_CTRL_AW-1:0] cprs_word_idx(input logic [AW-1:0] a);
    cprs_word_idx = a[`CPRS_CTRL_AW-1:0];
  endfunction : cprs_word_idx

  function automatic logic [`CPRS_CTRL_DW-1:0] cprs_word_data(input logic [AW-1:0] a);
    cprs_word_data = a[`CPRS_CTRL_AW +: `CPRS_CTRL_DW];
  endfunction : cprs_word_data

  // Rank three has no encoded code here; a module that needs it must use the direct quad mode.
  function automatic logic [SW-1:0] cprs_rank_sel(input logic [1:0] m, input logic [SW-1:0] cs);
    logic [SW-1:0] r;
    r = '1;
    unique case (m)
      `CPRS_MODE_DUAL: r = {2'h3, cs[1:0]};
      `CPRS_MODE_QUAD_DIRECT: r = cs;
      `CPRS_MODE_QUAD_ENC:
      begin
        // Encoded: cs0 active picks the pair, cs1 picks rank within it.
        if (!cs[0])
        begin
          r = ~(4'h1 << {cs[1], 1'b0});
        end
        else if (!cs[1])
        begin
          r = ~(4'h2);
        end
      end
      default: r = '1;
    endcase
    cprs_rank_sel = r;
  endfunction : cprs_rank_sel

  always_ff @(posedge clk)
  begin
    cs_s1_reg <= cs_in_n;
    cs_s2_reg <= cs_s1_reg;
    cmd_s1_reg <= cmd_in;
    cmd_s2_reg <= cmd_s1_reg;
    addr_s1_reg <= addr_in;
    addr_s2_reg <= addr_s1_reg;
    par_s1_reg <= cmd_addr_parity_in;
    par_s2_reg <= par_s1_reg;
    wr_s1_reg <= ctrl_word_wr;
    wr_s2_reg <= wr_s1_reg;
  end

  // All sixteen words are kept so the host can store its whole setup, though only two steer this block.
  cprs_ctrl_mem u_mem (
    .clk(clk),
    .srst(srst),
    .wr_en(mem_wr),
    .wr_addr(word_idx),
    .wr_data(word_data),
    .rd_addr(`CPRS_PAR_WORD_IDX),
    .rd_data(rd_data)
  );

  always_comb
  begin
    qualified = (cs_s2_reg != '1) || wr_s2_reg;
    word_idx = cprs_word_idx(addr_s2_reg);
    word_data = cprs_word_data(addr_s2_reg);
    mismatch = cprs_even_fail(cmd_s2_reg, addr_s2_reg, par_s2_reg);
    accept = qualified && !(parity_en_reg && mismatch);
    mem_wr = wr_s2_reg && accept;
    state_next = state_reg;
    cs_out_next = '1;
    cmd_out_next = cmd_out_reg;
    addr_out_next = addr_out_reg;
    valid_next = 1'b0;
    perr_next = 1'b0;
    parity_en_next = parity_en_reg;
    mode_next = mode_reg;
    alert_oe_n_next = 1'b1;
    alert_out_next = 1'b0;
    // An error wins over a control write, so a corrupted write never lands.
    if (qualified && parity_en_reg && mismatch)
    begin
      perr_next = 1'b1;
      alert_oe_n_next = 1'b0;
      state_next = cprs_pkg::CPRS_ST_ERR;
    end
    else if (accept && wr_s2_reg)
    begin
      state_next = cprs_pkg::CPRS_ST_IDLE;
      if (word_idx == `CPRS_PAR_WORD_IDX)
      begin
        parity_en_next = word_data[`CPRS_PAR_EN_BIT];
      end
      if (word_idx == `CPRS_CFG_WORD_IDX)
      begin
        // The reserved code is refused so the rank decode never sees it.
        if (word_data[`CPRS_MODE_LSB +: `CPRS_MODE_W] != `CPRS_MODE_RSVD)
        begin
          mode_next = word_data[`CPRS_MODE_LSB +: `CPRS_MODE_W];
        end
      end
    end
    else if (accept)
    begin
      state_next = cprs_pkg::CPRS_ST_FWD;
      cs_out_next = cprs_rank_sel(mode_reg, cs_s2_reg);
      cmd_out_next = cmd_s2_reg;
      addr_out_next = addr_s2_reg;
      valid_next = 1'b1;
    end
    else
    begin
      state_next = cprs_pkg::CPRS_ST_IDLE;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_reg <= cprs_pkg::CPRS_ST_IDLE;
      cs_out_reg <= '1;
      cmd_out_reg <= '0;
      addr_out_reg <= '0;
      valid_reg <= 1'b0;
      perr_reg <= 1'b0;
      // Checking starts off so a host that never programs it still gets commands through.
      parity_en_reg <= `CPRS_PAR_EN_RESET;
      mode_reg <= `CPRS_MODE_RESET;
      alert_oe_n_reg <= 1'b1;
      alert_out_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cs_out_reg <= cs_out_next;
      cmd_out_reg <= cmd_out_next;
      addr_out_reg <= addr_out_next;
      valid_reg <= valid_next;
      perr_reg <= perr_next;
      parity_en_reg <= parity_en_next;
      mode_reg <= mode_next;
      alert_oe_n_reg <= alert_oe_n_next;
      alert_out_reg <= alert_out_next;
    end
  end

  assign cs_out_n = cs_out_reg;
  assign cmd_out = cmd_out_reg;
  assign addr_out = addr_out_reg;
  assign cmd_valid_out = valid_reg;
  // Alert data stays low; the enable alone decides when the shared line is pulled.
  assign alert_out = alert_out_reg;
  // Open drain: enable low pulls the line low for one cycle per error.
  assign alert_oe_n = alert_oe_n_reg;
  assign parity_err_out = perr_reg;
  assign parity_en_out = parity_en_reg;
  assign rank_mode_field = mode_reg;
endmodule : cprs_top
`default_nettype wire

// [cprs_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module cprs_host_model (
  input wire logic [22:0] ca,
  input wire logic bad,
  output logic par
);
  assign par = ^ca ^ bad;
  // This host issues no refresh or mode-register loads, so hot refresh doubling and mirroring need no stimulus.
  // Control words reach the block over the command bus only; the serial path is the host's other choice.
endmodule : cprs_host_model
`default_nettype wire

// [cprs_top_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
module cprs_top_asserts #(
  parameter int AW = 18,
  parameter int CW = 5,
  parameter int SW = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [SW-1:0] cs_in_n,
  input wire logic [CW-1:0] cmd_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic cmd_addr_parity_in,
  input wire logic ctrl_word_wr,
  input wire logic [SW-1:0] cs_out_n,
  input wire logic cmd_valid_out,
  input wire logic alert_out,
  input wire logic alert_oe_n,
  input wire logic parity_err_out,
  input wire logic parity_en_out,
  input wire logic [1:0] rank_mode_field
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire logic odd = ^{cmd_in, addr_in, cmd_addr_parity_in};
  wire logic qc = !(&cs_in_n) && !ctrl_word_wr;
  // The enable is judged when the command is decoded, two cycles after the pins are sampled.
  sequence s_bad;
    qc && odd ##2 parity_en_out;
  endsequence
  sequence s_free;
    qc ##2 !parity_en_out;
  endsequence
  bad_drop_a: assert property (s_bad |-> ##1 parity_err_out && !cmd_valid_out)
    else $error("bad command sent");
  free_fwd_a: assert property (s_free |-> ##1 cmd_valid_out && !parity_err_out)
    else $error("command dropped");
  ctl_hold_a: assert property (ctrl_word_wr |-> ##3 !cmd_valid_out)
    else $error("write forwarded");
  err_cause_a: assert property (parity_err_out |-> $past(odd, 3))
    else $error("false error");
  err_alert_a: assert property (parity_err_out == !alert_oe_n)
    else $error("alert mismatch");
  alert_low_a: assert property (!alert_out)
    else $error("alert data high");
  idle_cs_a: assert property (!cmd_valid_out |-> cs_out_n == 4'hF)
    else $error("stray select");
  quad_cs_a: assert property (cmd_valid_out && rank_mode_field == 2'h1 |-> cs_out_n == $past(cs_in_n, 3))
    else $error("rank select");
  mode_ok_a: assert property (rank_mode_field != 2'h2)
    else $error("bad mode");
endmodule : cprs_top_asserts
bind cprs_top cprs_top_asserts #(.AW(AW), .CW(CW), .SW(SW)) u_chk (.*);
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic [3:0] cs_in_n = 4'hF;
  logic [4:0] cmd_in = 5'h0;
  logic [17:0] addr_in = 18'h0;
  logic ctrl_word_wr = 1'h0;
  logic bad = 1'h0;
  logic cmd_addr_parity_in;
  logic [3:0] cs_out_n;
  logic [4:0] cmd_out;
  logic [17:0] addr_out;
  logic cmd_valid_out, alert_out, alert_oe_n, parity_err_out, parity_en_out;
  logic [1:0] rank_mode_field;
  logic [31:0] q[$];
  logic [31:0] x;
  logic pen = 1'h0;
  logic [1:0] mode = 2'h0;
  logic [1:0] md [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  int n_fail = 0;
  int cmp_count = 0;
  always #50 clk = ~clk;
  cprs_host_model host (.ca({cmd_in, addr_in}), .bad(bad), .par(cmd_addr_parity_in));
  cprs_top dut (.*);
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Encoded mode: select 0 low picks rank 0 or 2 by select 1, else select 1 low picks rank 1.
  function automatic logic [3:0] exp_rank(logic [1:0] m, logic [3:0] cs);
    if (m == 2'h0) return {2'h3, cs[1:0]};
    if (m == 2'h1) return cs;
    if (!cs[0]) return cs[1] ? 4'hB : 4'hE;
    return cs[1] ? 4'hF : 4'hD;
  endfunction : exp_rank
  // Results trail the drive by three falling edges, so the model keeps a queue.
  task automatic cyc(logic [3:0] cs, logic ctl, logic b, logic [11:0] wa);
    logic qc;
    logic hit;
    logic v;
    @(negedge clk);
    cs_in_n = cs;
    ctrl_word_wr = ctl;
    bad = b;
    cmd_in = 5'($urandom);
    addr_in = ctl ? {6'h0, wa} : 18'($urandom);
    qc = !(&cs) && !ctl;
    hit = pen && b && (qc || ctl);
    v = qc && !hit;
    if (ctl && !hit && wa[3:0] == 4'hE) pen = wa[4];
    if (ctl && !hit && wa[3:0] == 4'hD && wa[5:4] != 2'h2) mode = wa[5:4];
    q.push_back({v, hit, v ? exp_rank(mode, cs) : 4'hF, cmd_in, addr_in, pen, mode});
    if (q.size() == 4)
    begin
      x = q.pop_front();
      chk("valid err", {30'h0, x[31:30]}, {30'h0, cmd_valid_out, parity_err_out});
      chk("alert", {30'h0, !x[30], 1'h0}, {30'h0, alert_oe_n, alert_out});
      chk("rank", {28'h0, x[29:26]}, {28'h0, cs_out_n});
      if (x[31]) chk("cmd addr", {9'h0, x[25:3]}, {9'h0, cmd_out, addr_out});
      chk("config", {29'h0, x[2:0]}, {29'h0, parity_en_out, rank_mode_field});
    end
  endtask : cyc
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test
  initial
  begin
    void'($urandom(27));
    repeat (16) @(negedge clk);
    srst = 1'h0;
    foreach (md[i])
      for (int p = 0; p < 2; p++)
      begin
        cyc(4'hF, 1'h1, !p[0], {8'(md[i]), 4'hD});
        repeat (4) cyc(4'hF, 1'h0, 1'h0, 12'h0);
        cyc(4'hF, 1'h1, 1'h0, {8'(p), 4'hE});
        repeat (4) cyc(4'hF, 1'h0, 1'h0, 12'h0);
        repeat (40) cyc(mode == 2'h0 ? {2'h3, 2'($urandom)} : 4'($urandom), 1'h0, 1'($urandom), 12'h0);
        $display("test mode %0d check %0d done", md[i], p);
      end
    repeat (5) cyc(4'hF, 1'h0, 1'h0, 12'h0);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
